// [include/mie_pkg.sv]
// constants and types shared by the instruction execute unit
package mie_pkg;
	// register bus offsets (byte addresses)
	localparam logic [7:0]  MIE_OFS_CTRL       = 8'h00;
	localparam logic [7:0]  MIE_OFS_PAGE       = 8'h04;
	localparam logic [7:0]  MIE_OFS_STATUS     = 8'h08;
	localparam logic [7:0]  MIE_OFS_PC         = 8'h0c;
	// control register fields and reset values
	localparam int          MIE_CTRL_RUN_BIT   = 0;
	localparam int          MIE_CTRL_2T_BIT    = 1;
	localparam logic [1:0]  MIE_CTRL_RESET     = 2'h1;
	localparam logic [7:0]  MIE_PAGE_RESET     = 8'h00;
	// status register field positions
	localparam int          MIE_ST_ACC_LSB     = 0;
	localparam int          MIE_ST_C_BIT       = 8;
	localparam int          MIE_ST_HALF_CARRY_BIT = 9;
	localparam int          MIE_ST_Z_BIT       = 10;
	localparam int          MIE_ST_TIMEOUT_BIT = 11;
	localparam int          MIE_ST_POWERDOWN_BIT = 12;
	localparam int          MIE_ST_IRQ_EN_BIT  = 13;
	localparam int          MIE_ST_PCH_LSB     = 16;
	// instruction period in oscillator periods, as last phase index
	localparam logic [1:0]  MIE_LAST_PHASE_4T  = 2'h3;
	localparam logic [1:0]  MIE_LAST_PHASE_2T  = 2'h1;
	// highest data location reachable by the register field
	localparam logic [7:0]  MIE_REG_MAX        = 8'hbf;
	localparam logic [10:0] MIE_PC_RESET       = 11'h000;
	// register-operand opcodes, bits 14:9
	localparam logic [5:0]  OP_MOVE_REG        = 6'h00;
	localparam logic [5:0]  OP_ADD_REG         = 6'h01;
	localparam logic [5:0]  OP_ADD_CARRY_REG   = 6'h02;
	localparam logic [5:0]  OP_SUB_ACC_FROM_REG = 6'h03;
	localparam logic [5:0]  OP_SUB_BORROW_REG  = 6'h04;
	localparam logic [5:0]  OP_AND_ACC_REG     = 6'h05;
	localparam logic [5:0]  OP_OR_ACC_REG      = 6'h06;
	localparam logic [5:0]  OP_XOR_ACC_REG     = 6'h07;
	localparam logic [5:0]  OP_INVERT_REG      = 6'h08;
	localparam logic [5:0]  OP_INC_REG         = 6'h09;
	localparam logic [5:0]  OP_DEC_REG         = 6'h0a;
	localparam logic [5:0]  OP_INC_SKIP_ZERO   = 6'h0b;
	localparam logic [5:0]  OP_DEC_SKIP_ZERO   = 6'h0c;
	localparam logic [5:0]  OP_ROTATE_LEFT_CIRCULAR  = 6'h0d;
	localparam logic [5:0]  OP_ROTATE_RIGHT_CIRCULAR = 6'h0e;
	localparam logic [5:0]  OP_SHIFT_LEFT_FILL_ZERO  = 6'h0f;
	localparam logic [5:0]  OP_SHIFT_LEFT_FILL_ONE   = 6'h10;
	localparam logic [5:0]  OP_SHIFT_RIGHT_FILL_ZERO = 6'h11;
	localparam logic [5:0]  OP_SHIFT_RIGHT_FILL_ONE  = 6'h12;
	localparam logic [5:0]  OP_ROTATE_LEFT_VIA_CARRY = 6'h13;
	localparam logic [5:0]  OP_ROTATE_RIGHT_VIA_CARRY = 6'h14;
	localparam logic [5:0]  OP_NIBBLE_EXCHANGE = 6'h15;
	localparam logic [5:0]  OP_DECIMAL_ADJUST_ADD = 6'h16;
	localparam logic [5:0]  OP_DECIMAL_ADJUST_SUB = 6'h17;
	localparam logic [5:0]  OP_ROM_LOOKUP_LOW  = 6'h18;
	localparam logic [5:0]  OP_ROM_LOOKUP_HIGH = 6'h19;
	localparam logic [5:0]  OP_SKIP_IF_REG_ZERO = 6'h1a;
	localparam logic [5:0]  OP_SKIP_IF_REG_NONZERO = 6'h1b;
	localparam logic [5:0]  OP_SKIP_IF_ACC_EQUAL_REG = 6'h1c;
	localparam logic [5:0]  OP_SKIP_IF_ACC_DIFFERS_REG = 6'h1d;
	localparam logic [5:0]  OP_MOVE_ACC_TO_REG = 6'h1e;
	localparam logic [5:0]  OP_CLEAR_REG       = 6'h1f;
	// literal opcodes, bits 11:8 under prefix 4'h8
	localparam logic [3:0]  OP_LIT_MOVE        = 4'h0;
	localparam logic [3:0]  OP_LIT_ADD         = 4'h1;
	localparam logic [3:0]  OP_SUB_ACC_FROM_LITERAL = 4'h2;
	localparam logic [3:0]  OP_LIT_AND         = 4'h3;
	localparam logic [3:0]  OP_LIT_OR          = 4'h4;
	localparam logic [3:0]  OP_LIT_XOR         = 4'h5;
	localparam logic [3:0]  OP_RETURN_WITH_LITERAL = 4'h6;
	// operand-free opcodes, bits 3:0 under prefix 4'h9
	localparam logic [3:0]  OP_NOP             = 4'h0;
	localparam logic [3:0]  OP_WATCHDOG_CLEAR  = 4'h1;
	localparam logic [3:0]  OP_SLEEP           = 4'h2;
	localparam logic [3:0]  OP_RETURN          = 4'h3;
	localparam logic [3:0]  OP_RETURN_IRQ_REENABLE = 4'h4;
	localparam logic [3:0]  OP_RETURN_IRQ_KEEP_MASKED = 4'h5;
	localparam logic [3:0]  OP_CLEAR_ACC       = 4'h6;
	localparam logic [3:0]  OP_SKIP_IF_ACC_ZERO = 4'h7;
	// instruction group prefixes
	localparam logic [3:0]  GRP_LITERAL        = 4'h8;
	localparam logic [3:0]  GRP_MISC           = 4'h9;
	localparam logic [2:0]  GRP_BIT            = 3'h5;
	localparam logic [1:0]  GRP_LONG           = 2'h3;
	// bit group kinds, bits 12:11
	localparam logic [1:0]  BIT_CLEAR_OP       = 2'h0;
	localparam logic [1:0]  BIT_SET_OP         = 2'h1;
	localparam logic [1:0]  BIT_TEST_SKIP_CLEAR = 2'h2;
	localparam logic [1:0]  BIT_TEST_SKIP_SET  = 2'h3;
	// what the second instruction cycle does
	typedef enum logic [1:0] {
		CYC_EXEC  = 2'b00,
		CYC_NOP   = 2'b01,
		CYC_TABLE = 2'b10
	} mie_cyc_type;
	typedef enum logic [1:0] {
		DST_NONE = 2'b00,
		DST_ACC  = 2'b01,
		DST_REG  = 2'b10
	} mie_dst_type;
endpackage : mie_pkg

// [src/mie_core.sv]
// instruction decode and execute unit with ahb-lite control registers
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
// Function
// RL1: table address is page high, register low
// RL2: table reads load low/high word byte, two cycles
// RL3: add decimal adjust fixes bcd, carry only
// RL4: subtract decimal adjust fixes bcd, carry only
// RL5: instruction period four or two oscillator periods
// RL6: bit test skips on clear/set, no flags
// RL7: bit clear/set one bit, no flags
// RL8: watchdog clear and sleep reset watchdog, flags
// RL9: returns pop stack; interrupt return sets enable
// RL10: literal return loads accumulator and pops stack
// RL11: long call pushes, long jump loads pc/high
// RL12: add/subtract forms update carry, half, zero
// RL13: logic ops and invert touch zero only
// RL14: inc/dec set zero; skip forms skip
// RL15: circular rotates and fill shifts change no flags
// RL16: carry rotates pass bit through carry
// RL17: nibble exchange swaps halves, no flags
// RL18: compare skips on zero/equal conditions
// RL19: destination bit picks accumulator or register
// RL20: register field 00h-bfh, bit selects eight
module mie_core
	import mie_pkg::*;
#(
	parameter int STACK_DEPTH = 8
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// program memory
	output logic      [10:0] pm_addr,
	input  wire logic [15:0] pm_data,
	// data register file
	output logic      [7:0]  rf_addr,
	input  wire logic [7:0]  rf_rdata,
	output logic      [7:0]  rf_wdata,
	output logic             rf_we,
	// watchdog, power control and interrupt enable
	output logic             wdt_clear,
	output logic             sleep_req,
	output logic             global_irq_enable
);
	import mie_pkg::*;

	localparam int SPW = $clog2(STACK_DEPTH);

	logic [1:0]  ctrl_q;
	logic [7:0]  lookup_page_reg_q;
	logic        wr_pend_q;
	logic [7:0]  wr_addr_q;
	logic [31:0] hrdata_q;
	logic [1:0]  phase_q;
	logic [1:0]  last_phase_q;
	mie_cyc_type cyc_q;
	logic [15:0] ir_q;
	logic [10:0] pc_q;
	logic [10:0] pm_addr_q;
	logic [7:0]  rf_addr_q;
	logic [7:0]  rf_wdata_q;
	logic        rf_we_q;
	logic [7:0]  acc_q;
	logic        carry_q;
	logic        half_carry_flag_q;
	logic        zero_q;
	logic        timeout_flag_q;
	logic        powerdown_flag_q;
	logic        global_irq_enable_q;
	logic [2:0]  pch_q;
	logic        wdt_clear_q;
	logic        sleep_q;
	logic [10:0] stack_q [STACK_DEPTH];
	logic [SPW-1:0] sp_q;

	logic        execute;
	logic        addr_phase;
	logic        reg_ok;
	logic [7:0]  r_val;
	logic [7:0]  res;
	mie_dst_type dst;
	logic        c_new;
	logic        dc_new;
	logic        z_new;
	logic        c_upd;
	logic        dc_upd;
	logic        z_upd;
	logic        skip;
	logic        do_push;
	logic        do_pop;
	logic        do_jump;
	logic        do_table;
	logic        irq_reenable;
	logic        wdt_op;
	logic        sleep_op;
	logic [10:0] target;
	logic [8:0]  sum9;
	logic [4:0]  sum5;
	logic [7:0]  adj;
	logic [7:0]  bitmask;

	// one instruction cycle ends when the phase counter reaches its last phase
	assign execute    = ctrl_q[MIE_CTRL_RUN_BIT] && (phase_q == last_phase_q);
	assign addr_phase = hsel && htrans[1] && hready;
	// data locations above the top of the map read as zero and take no write
	assign reg_ok     = (rf_addr_q <= MIE_REG_MAX); // [RL20]
	assign r_val      = reg_ok ? rf_rdata : 8'h00;
	assign bitmask    = 8'h01 << ir_q[10:8]; // [RL20]

	// ahb address phase capture; reads answer from a flop with zero wait states
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata_q  <= 32'h0000_0000;
		end else begin
			wr_pend_q <= addr_phase && hwrite;
			if (addr_phase) begin
				wr_addr_q <= haddr[7:0];
			end
			if (addr_phase && !hwrite) begin
				case (haddr[7:0])
					MIE_OFS_CTRL:   hrdata_q <= {30'h0000_0000, ctrl_q};
					MIE_OFS_PAGE:   hrdata_q <= {24'h00_0000, lookup_page_reg_q};
					MIE_OFS_STATUS: hrdata_q <= {13'h0000, pch_q, 2'h0,
						global_irq_enable_q, powerdown_flag_q, timeout_flag_q,
						zero_q, half_carry_flag_q, carry_q, acc_q};
					MIE_OFS_PC:     hrdata_q <= {21'h00_0000, pc_q};
					default:        hrdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ahb data phase writes to the control and page registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q            <= MIE_CTRL_RESET;
			lookup_page_reg_q <= MIE_PAGE_RESET;
		end else if (wr_pend_q) begin
			case (wr_addr_q)
				MIE_OFS_CTRL: ctrl_q            <= hwdata[1:0];
				MIE_OFS_PAGE: lookup_page_reg_q <= hwdata[7:0];
				default:      ;
			endcase
		end
	end

	// phase counter; the period setting is only taken at a cycle boundary so
	// that a change never truncates the instruction in flight
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_q      <= 2'h0;
			last_phase_q <= MIE_LAST_PHASE_4T;
		end else if (!ctrl_q[MIE_CTRL_RUN_BIT]) begin
			phase_q <= 2'h0;
		end else if (execute) begin
			phase_q      <= 2'h0;
			last_phase_q <= ctrl_q[MIE_CTRL_2T_BIT] ? MIE_LAST_PHASE_2T
			                                        : MIE_LAST_PHASE_4T; // [RL5]
		end else begin
			phase_q <= 2'(phase_q + 2'h1); // [RL5]
		end
	end

	// fetch in phase 0: latch the instruction, except in a table cycle, which keeps the lookup instruction
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ir_q      <= 16'h0000;
			rf_addr_q <= 8'h00;
		end else if (phase_q == 2'h0 && cyc_q != CYC_TABLE) begin
			ir_q      <= pm_data;
			rf_addr_q <= pm_data[7:0];
		end
	end

	// decimal adjust helpers
	always_comb begin
		adj = 8'h00;
		if (ir_q[14:9] == OP_DECIMAL_ADJUST_ADD) begin
			if (r_val[3:0] > 4'h9 || half_carry_flag_q) adj[3:0] = 4'h6;
			if (r_val > 8'h99 || carry_q) adj[7:4] = 4'h6;
		end else begin
			if (r_val[3:0] > 4'h9 || !half_carry_flag_q) adj[3:0] = 4'h6;
			if (!carry_q) adj[7:4] = 4'h6;
		end
	end

	// decode and alu
	always_comb begin
		res = 8'h00; dst = DST_NONE; skip = 1'b0;
		c_new = carry_q; dc_new = half_carry_flag_q; z_new = zero_q;
		c_upd = 1'b0; dc_upd = 1'b0; z_upd = 1'b0;
		do_push = 1'b0; do_pop = 1'b0; do_jump = 1'b0; do_table = 1'b0;
		irq_reenable = 1'b0; wdt_op = 1'b0; sleep_op = 1'b0;
		target = ir_q[10:0];
		sum9 = 9'h000; sum5 = 5'h00;
		if (ir_q[15:14] == GRP_LONG) begin
			do_jump = 1'b1; // [RL11]
			do_push = ir_q[13]; // [RL11]
		end else if (ir_q[15:13] == GRP_BIT) begin
			case (ir_q[12:11])
				BIT_CLEAR_OP: begin res = r_val & ~bitmask; dst = DST_REG; end // [RL7]
				BIT_SET_OP:   begin res = r_val | bitmask;  dst = DST_REG; end // [RL7]
				BIT_TEST_SKIP_CLEAR: skip = ((r_val & bitmask) == 8'h00); // [RL6]
				default:             skip = ((r_val & bitmask) != 8'h00); // [RL6]
			endcase
		end else if (ir_q[15:12] == GRP_LITERAL) begin
			dst = DST_ACC;
			case (ir_q[11:8])
				OP_LIT_MOVE: res = ir_q[7:0];
				OP_LIT_ADD: begin
					sum9 = {1'b0, ir_q[7:0]} + {1'b0, acc_q};
					sum5 = {1'b0, ir_q[3:0]} + {1'b0, acc_q[3:0]};
				end
				OP_SUB_ACC_FROM_LITERAL: begin
					sum9 = {1'b0, ir_q[7:0]} + {1'b0, ~acc_q} + 9'h001; // [RL12]
					sum5 = {1'b0, ir_q[3:0]} + {1'b0, ~acc_q[3:0]} + 5'h01;
				end
				OP_LIT_AND: begin res = acc_q & ir_q[7:0]; z_upd = 1'b1; end
				OP_LIT_OR:  begin res = acc_q | ir_q[7:0]; z_upd = 1'b1; end
				OP_LIT_XOR: begin res = acc_q ^ ir_q[7:0]; z_upd = 1'b1; end
				OP_RETURN_WITH_LITERAL: begin res = ir_q[7:0]; do_pop = 1'b1; end // [RL10]
				default: dst = DST_NONE;
			endcase
			if (ir_q[11:8] == OP_LIT_ADD || ir_q[11:8] == OP_SUB_ACC_FROM_LITERAL) begin
				res = sum9[7:0]; c_upd = 1'b1; dc_upd = 1'b1; z_upd = 1'b1;
			end
		end else if (ir_q[15:12] == GRP_MISC) begin
			case (ir_q[3:0])
				OP_WATCHDOG_CLEAR: wdt_op = 1'b1; // [RL8]
				OP_SLEEP:          sleep_op = 1'b1; // [RL8]
				OP_RETURN:         do_pop = 1'b1; // [RL9]
				OP_RETURN_IRQ_REENABLE: begin do_pop = 1'b1; irq_reenable = 1'b1; end // [RL9]
				OP_RETURN_IRQ_KEEP_MASKED: do_pop = 1'b1; // [RL9]
				OP_CLEAR_ACC: begin dst = DST_ACC; z_upd = 1'b1; end
				OP_SKIP_IF_ACC_ZERO: skip = (acc_q == 8'h00); // [RL18]
				default: ;
			endcase
		end else begin
			// destination bit picks accumulator or register
			dst = ir_q[8] ? DST_REG : DST_ACC; // [RL19]
			case (ir_q[14:9])
				OP_MOVE_REG: begin res = r_val; z_upd = 1'b1; end
				OP_ADD_REG, OP_ADD_CARRY_REG: begin
					sum9 = {1'b0, r_val} + {1'b0, acc_q} +
						{8'h00, (ir_q[14:9] == OP_ADD_CARRY_REG) & carry_q}; // [RL12]
					sum5 = {1'b0, r_val[3:0]} + {1'b0, acc_q[3:0]} +
						{4'h0, (ir_q[14:9] == OP_ADD_CARRY_REG) & carry_q};
				end
				OP_SUB_ACC_FROM_REG, OP_SUB_BORROW_REG: begin
					sum9 = {1'b0, r_val} + {1'b0, ~acc_q} +
						{8'h00, (ir_q[14:9] == OP_SUB_ACC_FROM_REG) | carry_q}; // [RL12]
					sum5 = {1'b0, r_val[3:0]} + {1'b0, ~acc_q[3:0]} +
						{4'h0, (ir_q[14:9] == OP_SUB_ACC_FROM_REG) | carry_q};
				end
				OP_AND_ACC_REG: begin res = acc_q & r_val; z_upd = 1'b1; end // [RL13]
				OP_OR_ACC_REG:  begin res = acc_q | r_val; z_upd = 1'b1; end // [RL13]
				OP_XOR_ACC_REG: begin res = acc_q ^ r_val; z_upd = 1'b1; end // [RL13]
				OP_INVERT_REG:  begin res = ~r_val;        z_upd = 1'b1; end // [RL13]
				OP_INC_REG: begin res = 8'(r_val + 8'h01); z_upd = 1'b1; end // [RL14]
				OP_DEC_REG: begin res = 8'(r_val - 8'h01); z_upd = 1'b1; end // [RL14]
				OP_INC_SKIP_ZERO: begin
					res = 8'(r_val + 8'h01); skip = (res == 8'h00); // [RL14]
				end
				OP_DEC_SKIP_ZERO: begin
					res = 8'(r_val - 8'h01); skip = (res == 8'h00); // [RL14]
				end
				OP_ROTATE_LEFT_CIRCULAR:  res = {r_val[6:0], r_val[7]}; // [RL15]
				OP_ROTATE_RIGHT_CIRCULAR: res = {r_val[0], r_val[7:1]}; // [RL15]
				OP_SHIFT_LEFT_FILL_ZERO:  res = {r_val[6:0], 1'b0}; // [RL15]
				OP_SHIFT_LEFT_FILL_ONE:   res = {r_val[6:0], 1'b1}; // [RL15]
				OP_SHIFT_RIGHT_FILL_ZERO: res = {1'b0, r_val[7:1]}; // [RL15]
				OP_SHIFT_RIGHT_FILL_ONE:  res = {1'b1, r_val[7:1]}; // [RL15]
				OP_ROTATE_LEFT_VIA_CARRY: begin
					res = {r_val[6:0], carry_q}; c_new = r_val[7]; c_upd = 1'b1; // [RL16]
				end
				OP_ROTATE_RIGHT_VIA_CARRY: begin
					res = {carry_q, r_val[7:1]}; c_new = r_val[0]; c_upd = 1'b1; // [RL16]
				end
				OP_NIBBLE_EXCHANGE: res = {r_val[3:0], r_val[7:4]}; // [RL17]
				OP_DECIMAL_ADJUST_ADD: begin
					sum9 = {1'b0, r_val} + {1'b0, adj}; // [RL3]
					res = sum9[7:0];
					c_new = sum9[8] | carry_q | (r_val > 8'h99); c_upd = 1'b1; // [RL3]
				end
				OP_DECIMAL_ADJUST_SUB: begin
					res = 8'(r_val - adj); // [RL4]
					c_new = carry_q; c_upd = 1'b1; // [RL4]
				end
				OP_ROM_LOOKUP_LOW, OP_ROM_LOOKUP_HIGH: begin
					dst = DST_NONE; do_table = 1'b1; // [RL2]
				end
				OP_SKIP_IF_REG_ZERO:    begin dst = DST_NONE; skip = (r_val == 8'h00); end // [RL18]
				OP_SKIP_IF_REG_NONZERO: begin dst = DST_NONE; skip = (r_val != 8'h00); end // [RL18]
				OP_SKIP_IF_ACC_EQUAL_REG: begin
					dst = DST_NONE; skip = (acc_q == r_val); // [RL18]
				end
				OP_SKIP_IF_ACC_DIFFERS_REG: begin
					dst = DST_NONE; skip = (acc_q != r_val); // [RL18]
				end
				OP_MOVE_ACC_TO_REG: begin res = acc_q; dst = DST_REG; end
				OP_CLEAR_REG: begin dst = DST_REG; z_upd = 1'b1; end
				default: dst = DST_NONE;
			endcase
			if (ir_q[14:9] >= OP_ADD_REG && ir_q[14:9] <= OP_SUB_BORROW_REG) begin
				res = sum9[7:0]; c_upd = 1'b1; dc_upd = 1'b1; z_upd = 1'b1; // [RL12]
			end
		end
		if (c_upd && dc_upd) begin
			c_new  = sum9[8]; // [RL12]
			dc_new = sum5[4]; // [RL12]
		end
		z_new = (res == 8'h00);
	end

	// program counter, fetch address, stack and second-cycle sequencing
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pc_q      <= MIE_PC_RESET;
			pm_addr_q <= MIE_PC_RESET;
			cyc_q     <= CYC_EXEC;
			sp_q      <= '0;
			pch_q     <= 3'h0;
			for (int i = 0; i < STACK_DEPTH; i++) stack_q[i] <= 11'h000;
		end else if (execute) begin
			if (cyc_q == CYC_TABLE) begin
				pm_addr_q <= pc_q;
				cyc_q     <= CYC_EXEC;
			end else if (cyc_q == CYC_NOP) begin
				cyc_q <= CYC_EXEC;
			end else if (do_jump) begin
				if (do_push) begin
					stack_q[sp_q] <= 11'(pc_q + 11'h001); // [RL11]
					sp_q          <= SPW'(sp_q + 1'b1);
				end
				pc_q      <= target; // [RL11]
				pm_addr_q <= target;
				pch_q     <= target[10:8]; // [RL11]
				cyc_q     <= CYC_NOP; // [RL11]
			end else if (do_pop) begin
				pc_q      <= stack_q[SPW'(sp_q - 1'b1)]; // [RL9] [RL10]
				pm_addr_q <= stack_q[SPW'(sp_q - 1'b1)];
				sp_q      <= SPW'(sp_q - 1'b1);
				cyc_q     <= CYC_NOP; // [RL9] [RL10]
			end else if (do_table) begin
				pc_q      <= 11'(pc_q + 11'h001);
				pm_addr_q <= 11'({lookup_page_reg_q, r_val}); // [RL1]
				cyc_q     <= CYC_TABLE; // [RL2]
			end else if (skip) begin
				pc_q      <= 11'(pc_q + 11'h002); // [RL6] [RL14] [RL18]
				pm_addr_q <= 11'(pc_q + 11'h002);
				cyc_q     <= CYC_NOP; // [RL6] [RL14] [RL18]
			end else begin
				pc_q      <= 11'(pc_q + 11'h001);
				pm_addr_q <= 11'(pc_q + 11'h001);
			end
		end
	end

	// accumulator, flags and register write-back; nothing retires in a nop cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_q <= 8'h00;
			carry_q <= 1'b0;
			half_carry_flag_q <= 1'b0;
			zero_q <= 1'b0;
			rf_we_q <= 1'b0;
			rf_wdata_q <= 8'h00;
		end else begin
			rf_we_q <= 1'b0;
			if (execute && cyc_q == CYC_TABLE) begin
				acc_q <= (ir_q[14:9] == OP_ROM_LOOKUP_HIGH) ? pm_data[15:8] : pm_data[7:0]; // [RL2]
			end else if (execute && cyc_q == CYC_EXEC) begin
				if (dst == DST_ACC) acc_q <= res; // [RL19]
				if (dst == DST_REG && reg_ok) begin
					rf_we_q    <= 1'b1; // [RL19] [RL20]
					rf_wdata_q <= res;
				end
				if (c_upd)  carry_q <= c_new;
				if (dc_upd) half_carry_flag_q <= dc_new;
				if (z_upd)  zero_q <= z_new;
			end
		end
	end

	// watchdog clear and sleep pulses, status flags, interrupt enable
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wdt_clear_q <= 1'b0;
			sleep_q <= 1'b0;
			timeout_flag_q <= 1'b1;
			powerdown_flag_q <= 1'b1;
			global_irq_enable_q <= 1'b0;
		end else begin
			wdt_clear_q <= execute && cyc_q == CYC_EXEC && (wdt_op || sleep_op); // [RL8]
			sleep_q     <= execute && cyc_q == CYC_EXEC && sleep_op;
			if (execute && cyc_q == CYC_EXEC && wdt_op) begin
				timeout_flag_q   <= 1'b1; // [RL8]
				powerdown_flag_q <= 1'b1;
			end
			if (execute && cyc_q == CYC_EXEC && sleep_op) begin
				timeout_flag_q   <= 1'b1; // [RL8]
				powerdown_flag_q <= 1'b0;
			end
			if (execute && cyc_q == CYC_EXEC && irq_reenable) begin
				global_irq_enable_q <= 1'b1; // [RL9]
			end
		end
	end

	// outputs straight from flops; hreadyout and hresp are tied constants
	assign hrdata            = hrdata_q;
	assign hreadyout         = 1'b1;
	assign hresp             = 1'b0;
	assign pm_addr           = pm_addr_q;
	assign rf_addr           = rf_addr_q;
	assign rf_wdata          = rf_wdata_q;
	assign rf_we             = rf_we_q;
	assign wdt_clear         = wdt_clear_q;
	assign sleep_req         = sleep_q;
	assign global_irq_enable = global_irq_enable_q;
endmodule : mie_core

// [dv/mie_mem_model.sv]
// program memory and data register file facing the execute unit
`timescale 1ns/1ps
module mie_mem_model (
	// clock
	input  wire logic        clk,
	// program memory
	input  wire logic [10:0] pm_addr,
	output logic      [15:0] pm_data,
	// register file
	input  wire logic [7:0]  rf_addr,
	output logic      [7:0]  rf_rdata,
	input  wire logic [7:0]  rf_wdata,
	input  wire logic        rf_we
);
	logic [15:0] rom [2048];
	logic [7:0]  ram [256];
	// reads are combinational because the core samples them in the same cycle
	assign pm_data  = rom[pm_addr];
	assign rf_rdata = ram[rf_addr];
	// a write lands at the edge that ends the strobe cycle
	always @(posedge clk) begin
		if (rf_we) begin
			ram[rf_addr] <= rf_wdata;
		end
	end
endmodule : mie_mem_model

// [dv/mie_core_props.sv]
// port assertions for the execute unit
`timescale 1ns/1ps
module mie_core_props (
	// bus side
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	// core side
	input wire logic [10:0] pm_addr,
	input wire logic [7:0]  rf_addr,
	input wire logic        rf_we,
	input wire logic        wdt_clear,
	input wire logic        sleep_req
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// read request to an offset beyond the register map
	sequence odd_rd_s;
		hsel && htrans[1] && hreadyout && !hwrite && haddr > 32'hc && haddr < 32'h100;
	endsequence
	zero_wait_a: assert property (hreadyout) else $error("wait state seen");
	odd_read_a: assert property (odd_rd_s |=> hrdata == 32'h0) else $error("unmapped read");
	reg_range_a: assert property (rf_we |-> rf_addr <= 8'hbf) else $error("bad write");
	we_pulse_a: assert property (rf_we |=> !rf_we) else $error("long write");
	we_addr_a: assert property (rf_we |-> $stable(rf_addr)) else $error("addr moved");
	wdt_pulse_a: assert property (wdt_clear |=> !wdt_clear) else $error("long clear");
	sleep_wdt_a: assert property (sleep_req |-> wdt_clear) else $error("no clear");
	pc_hold_a: assert property ($changed(pm_addr) |=> $stable(pm_addr)) else $error("short");
endmodule : mie_core_props
// attach to every core instance
bind mie_core mie_core_props i_mie_core_props (.clk, .reset_n, .hsel, .haddr, .htrans,
	.hwrite, .hrdata, .hreadyout, .pm_addr, .rf_addr, .rf_we, .wdt_clear, .sleep_req);

// [dv/mcu_core_instruction_exec_tb.sv]
// self-checking bench for the execute unit
`timescale 1ns/1ps
module mcu_core_instruction_exec_tb;
	import mie_pkg::*;
	logic        clk = 0, reset_n = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
	logic        rf_we, wdt_clear, sleep_req, global_irq_enable;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
	logic [1:0]  htrans = 0;
	logic [10:0] pm_addr;
	logic [15:0] pm_data, w, p [28];
	logic [7:0]  rf_addr, rf_rdata, rf_wdata, a, b;
	logic [8:0]  e;
	int          error_cnt = 0, check_count = 0, n, wdt_cnt = 0, slp_cnt = 0;
	// 250 MHz
	always #2 clk = ~clk;
	// pulses counted mid-cycle, so each one-cycle pulse counts once
	always @(negedge clk) begin
		wdt_cnt += wdt_clear;
		slp_cnt += sleep_req;
	end
	mie_core i_mie_core (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pm_addr, .pm_data,
		.rf_addr, .rf_rdata, .rf_wdata, .rf_we, .wdt_clear, .sleep_req, .global_irq_enable);
	mie_mem_model i_mie_mem_model (.clk, .pm_addr, .pm_data, .rf_addr, .rf_rdata,
		.rf_wdata, .rf_we);
	// decimal sum of two packed bcd bytes, carry on top
	function automatic logic [8:0] bcd_sum(logic [7:0] x, logic [7:0] y);
		int s;
		s = x[7:4] * 10 + x[3:0] + y[7:4] * 10 + y[3:0];
		return {s > 99, 4'(s % 100 / 10), 4'(s % 10)};
	endfunction : bcd_sum
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// single word transfer; each phase held until hready is sampled high
	task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, ofs};
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : ahb
	// sampled mid-cycle so the edge updates have landed; n counts edges
	task automatic wait_pc(input logic [10:0] v);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (pm_addr !== v && n < 400);
	endtask : wait_pc
	task automatic results();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results
	// hang guard, far beyond two passes
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		results();
	end
	// pass 0 runs the default period, pass 1 the short one
	initial begin
		void'($urandom(40326));
		for (int m = 0; m < 2; m++) begin
			a = {4'($urandom % 10), 4'($urandom % 10)};
			b = {4'($urandom % 10), 4'($urandom % 10)};
			w = 16'($urandom);
			p = '{{GRP_LITERAL, OP_LIT_MOVE, a}, {1'b0, OP_MOVE_ACC_TO_REG, 9'h140},
				{GRP_LITERAL, OP_LIT_MOVE, b}, {1'b0, OP_ADD_REG, 9'h140},
				{1'b0, OP_DECIMAL_ADJUST_ADD, 9'h040}, {1'b0, OP_MOVE_ACC_TO_REG, 9'h150},
				{GRP_LITERAL, OP_LIT_MOVE, 8'h03}, {1'b0, OP_MOVE_ACC_TO_REG, 9'h141},
				{1'b0, OP_ROM_LOOKUP_LOW, 9'h041}, {1'b0, OP_MOVE_ACC_TO_REG, 9'h151},
				{1'b0, OP_ROM_LOOKUP_HIGH, 9'h041}, {1'b0, OP_MOVE_ACC_TO_REG, 9'h152},
				{GRP_BIT, BIT_SET_OP, 11'h052}, {GRP_BIT, BIT_CLEAR_OP, 11'h252},
				{GRP_BIT, BIT_TEST_SKIP_SET, 11'h051}, {1'b0, OP_INC_REG, 9'h153},
				{GRP_LONG, 3'h4, 11'd64}, {1'b0, OP_MOVE_ACC_TO_REG, 9'h154},
				{GRP_LONG, 3'h4, 11'd65}, {GRP_MISC, 8'h0, OP_SLEEP},
				{GRP_MISC, 8'h0, OP_WATCHDOG_CLEAR}, {1'b0, OP_NIBBLE_EXCHANGE, 9'h151},
				{1'b0, OP_ROTATE_RIGHT_VIA_CARRY, 9'h150},
				{1'b0, OP_ROTATE_LEFT_CIRCULAR, 9'h153}, {1'b0, OP_MOVE_ACC_TO_REG, 9'h1c0},
				{1'b0, OP_SKIP_IF_ACC_EQUAL_REG, 9'h054}, {1'b0, OP_INC_REG, 9'h154},
				{GRP_LONG, 3'h0, 11'd27}};
			for (int i = 0; i < 2048; i++) i_mie_mem_model.rom[i] = 16'h0;
			for (int i = 0; i < 28; i++) i_mie_mem_model.rom[i] = p[i];
			i_mie_mem_model.rom[64] = {GRP_LITERAL, OP_RETURN_WITH_LITERAL, 8'h77};
			i_mie_mem_model.rom[65] = {GRP_MISC, 8'h0, OP_RETURN_IRQ_REENABLE};
			i_mie_mem_model.rom[11'h703] = w;
			for (int i = 0; i < 256; i++) i_mie_mem_model.ram[i] = i > 'hbf ? 8'ha5 : 8'h0;
			wdt_cnt = 0;
			slp_cnt = 0;
			reset_n <= 1'b0;
			repeat (10) @(posedge clk);
			reset_n <= 1'b1;
			ahb(1'b1, MIE_OFS_CTRL, {30'h0, m[0], 1'b1}, r);
			ahb(1'b1, MIE_OFS_PAGE, 32'h7, r);
			wait_pc(11'd6);
			wait_pc(11'd7);
			chk(n, m[0] ? 32'd2 : 32'd4);
			ahb(1'b0, MIE_OFS_CTRL, 32'h0, r);
			chk(r, {30'h0, m[0], 1'b1});
			ahb(1'b0, 8'h10, 32'h0, r);
			chk(r, 32'h0);
			wait_pc(11'd27);
			repeat (4) @(negedge clk);
			e = bcd_sum(a, b);
			chk(i_mie_mem_model.ram[8'h40], 8'(a + b));
			chk(i_mie_mem_model.ram[8'h50], {e[8], e[7:1]});
			chk(i_mie_mem_model.ram[8'h51], {w[3:0], w[7:4]});
			chk(i_mie_mem_model.ram[8'h52], w[15:8] & 8'hfb | 8'h01);
			chk(i_mie_mem_model.ram[8'h53], {6'h0, !w[0], 1'b0});
			chk(i_mie_mem_model.ram[8'h54], 8'h77);
			chk(i_mie_mem_model.ram[8'hc0], 8'ha5);
			chk(wdt_cnt, 32'd2);
			chk(slp_cnt, 32'd1);
			ahb(1'b0, MIE_OFS_STATUS, 32'h0, r);
			chk(r[7:0], 8'h77);
			chk(r[MIE_ST_C_BIT], e[0]);
			chk(r[MIE_ST_POWERDOWN_BIT:MIE_ST_TIMEOUT_BIT], 2'h3);
			chk(global_irq_enable, 1'b1);
			ahb(1'b0, MIE_OFS_PC, 32'h0, r);
			chk(r[10:0], 11'd27);
		end
		results();
	end
endmodule : mcu_core_instruction_exec_tb
